// ---- rtl/uim_pkg.sv ----
package uim_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] UIM_ADDR_ENABLE = 16'hFFFD;
    localparam logic [15:0] UIM_ADDR_STATUS = 16'hFFF0;
    localparam logic [15:0] UIM_ADDR_VECTOR = 16'hFFF1;

    // ************************************************************
    // Field positions, shared by enable and status
    // ************************************************************
    localparam int unsigned UIM_BIT_BUS_RESET = 7;
    localparam int unsigned UIM_BIT_SUSPEND = 6;
    localparam int unsigned UIM_BIT_RESUME = 5;
    localparam int unsigned UIM_BIT_FRAME = 4;
    localparam int unsigned UIM_BIT_PSEUDO_FRAME = 3;
    localparam int unsigned UIM_BIT_SETUP_DONE = 2;
    localparam int unsigned UIM_BIT_RESERVED = 1;
    localparam int unsigned UIM_BIT_SETUP_OVERWRITE = 0;

    localparam logic [7:0] UIM_IMPL_BITS = 8'hFD;
    localparam logic [7:0] UIM_ENABLE_RESET = 8'h00;
    localparam logic [7:0] UIM_STATUS_RESET = 8'h00;
    localparam logic [7:0] UIM_READ_IDLE = 8'h00;
    localparam logic [7:0] UIM_CLEAR_ALL = 8'hFF;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned UIM_CLK_PERIOD_NS = 10;
    localparam int unsigned UIM_PSEUDO_FRAME_NS = 1000000;
    localparam int unsigned UIM_PSEUDO_FRAME_CYCLES = UIM_PSEUDO_FRAME_NS / UIM_CLK_PERIOD_NS;
    localparam int unsigned UIM_FRAME_CNT_W = 17;
    localparam logic [UIM_FRAME_CNT_W-1:0] UIM_FRAME_CNT_RESET = 17'h00000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uim_bus_req_t;

    typedef struct packed {
        logic bus_reset;
        logic suspend;
        logic resume;
        logic frame;
        logic setup_done;
    } uim_evt_t;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] status;
        logic [UIM_FRAME_CNT_W-1:0] frame_cnt;
        logic [7:0] rd_data;
        logic [7:0] pending;
        logic irq;
    } uim_state_t;

endpackage

// ---- rtl/uim_top.sv ----
// Summary of operation
// - An event raises the interrupt only while its status bit and its enable bit are both one.
// - Enable bit 7 lets a detected bus reset interrupt the controller.
// - Enable bit 6 lets a detected suspend interrupt the controller.
// - Enable bit 4 lets a received start-of-frame packet interrupt the controller.
// - Enable bit 3 lets the locally made pseudo start-of-frame interrupt the controller.
// - Enable bit 2 lets a completed control setup stage interrupt the controller.
// - Enable bit 0 lets an overwritten setup buffer interrupt the controller.
// - Bit 1 is reserved, reads zero, ignores writes and gates nothing.
// - Status bits are set by hardware and cleared by a write to the vector register.
// - A pseudo start-of-frame fires every 1 ms while the frame timer is not locked.
// - A new setup stage arriving over an unserviced one flags a setup overwrite.
module uim_top #(
    parameter int unsigned PSEUDO_FRAME_CYCLES = uim_pkg::UIM_PSEUDO_FRAME_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire uim_pkg::uim_bus_req_t bus_i,
    input wire uim_pkg::uim_evt_t evt_i,
    input wire logic frame_locked_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] pending_o,
    output logic irq_o
);
    import uim_pkg::*;

    localparam logic [UIM_FRAME_CNT_W-1:0] FRAME_LAST =
        UIM_FRAME_CNT_W'(PSEUDO_FRAME_CYCLES - 1);

    uim_state_t s_reg;
    uim_state_t s_next;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic wr_enable;
    logic wr_status;
    logic wr_vector;

    assign wr_enable = bus_i.wr && (bus_i.addr == UIM_ADDR_ENABLE);
    assign wr_status = bus_i.wr && (bus_i.addr == UIM_ADDR_STATUS);
    assign wr_vector = bus_i.wr && (bus_i.addr == UIM_ADDR_VECTOR);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        set_v = UIM_STATUS_RESET;
        clr_v = UIM_STATUS_RESET;

        set_v[UIM_BIT_BUS_RESET] = evt_i.bus_reset;
        set_v[UIM_BIT_SUSPEND] = evt_i.suspend;
        set_v[UIM_BIT_RESUME] = evt_i.resume;
        set_v[UIM_BIT_FRAME] = evt_i.frame;
        set_v[UIM_BIT_SETUP_DONE] = evt_i.setup_done;
        // Host restarted control transfer before firmware read the buffer
        set_v[UIM_BIT_SETUP_OVERWRITE] = evt_i.setup_done
            && s_reg.status[UIM_BIT_SETUP_DONE];

        // Free-running local frame timer, idle while locked to the host
        if (frame_locked_i) begin
            s_next.frame_cnt = UIM_FRAME_CNT_RESET;
        end else if (s_reg.frame_cnt >= FRAME_LAST) begin
            s_next.frame_cnt = UIM_FRAME_CNT_RESET;
            set_v[UIM_BIT_PSEUDO_FRAME] = 1'b1;
        end else begin
            s_next.frame_cnt = s_reg.frame_cnt + UIM_FRAME_CNT_W'(1);
        end

        // Vector write clears everything; status write clears ones written
        if (wr_vector) begin
            clr_v = UIM_CLEAR_ALL;
        end else if (wr_status) begin
            clr_v = bus_i.wdata;
        end
        // Set wins so an event in the clearing cycle is kept
        s_next.status = ((s_reg.status & ~clr_v) | set_v) & UIM_IMPL_BITS;

        if (wr_enable) begin
            s_next.enable = bus_i.wdata & UIM_IMPL_BITS;
        end

        s_next.rd_data = UIM_READ_IDLE;
        if (bus_i.rd) begin
            case (bus_i.addr)
                UIM_ADDR_ENABLE: s_next.rd_data = s_reg.enable;
                UIM_ADDR_STATUS: s_next.rd_data = s_reg.status;
                default: s_next.rd_data = UIM_READ_IDLE;
            endcase
        end

        // Gating uses the next values so irq_o lines up with status
        s_next.pending = s_next.status & s_next.enable;
        s_next.irq = |s_next.pending;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg.enable <= UIM_ENABLE_RESET;
            s_reg.status <= UIM_STATUS_RESET;
            s_reg.frame_cnt <= UIM_FRAME_CNT_RESET;
            s_reg.rd_data <= UIM_READ_IDLE;
            s_reg.pending <= UIM_STATUS_RESET;
            s_reg.irq <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data_o = s_reg.rd_data;
    assign pending_o = s_reg.pending;
    assign irq_o = s_reg.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_enable_wr;
        bus_i.wr && (bus_i.addr == UIM_ADDR_ENABLE);
    endsequence

    sequence s_enable_rd;
        bus_i.rd && (bus_i.addr == UIM_ADDR_ENABLE);
    endsequence

    sequence s_no_clear;
        !(bus_i.wr && (bus_i.addr == UIM_ADDR_VECTOR || bus_i.addr == UIM_ADDR_STATUS));
    endsequence

    sequence s_status_rd;
        bus_i.rd && (bus_i.addr == UIM_ADDR_STATUS);
    endsequence

    sequence s_vector_rd;
        bus_i.rd && (bus_i.addr == UIM_ADDR_VECTOR);
    endsequence

    // Two setup completions, nothing clearing the first before the second
    sequence s_setup_twice;
        evt_i.setup_done ##1 !(wr_vector || wr_status) ##1 evt_i.setup_done;
    endsequence

    a_irq_gating: assert property (
        irq_o == ((s_reg.status & s_reg.enable) != 8'h00))
        else $error("interrupt does not follow status and enable");

    a_bus_reset_irq: assert property (
        s_reg.status[UIM_BIT_BUS_RESET] && s_reg.enable[UIM_BIT_BUS_RESET] |-> irq_o)
        else $error("enabled bus reset did not interrupt");

    a_suspend_irq: assert property (
        s_reg.status[UIM_BIT_SUSPEND] && s_reg.enable[UIM_BIT_SUSPEND] |-> irq_o)
        else $error("enabled suspend did not interrupt");

    a_resume_irq: assert property (
        s_reg.status[UIM_BIT_RESUME] && s_reg.enable[UIM_BIT_RESUME] |-> irq_o)
        else $error("enabled resume did not interrupt");

    a_frame_irq: assert property (
        evt_i.frame && s_reg.enable[UIM_BIT_FRAME] && !bus_i.wr |=> irq_o)
        else $error("enabled frame event did not interrupt next cycle");

    a_pseudo_irq: assert property (
        s_reg.status[UIM_BIT_PSEUDO_FRAME] && s_reg.enable[UIM_BIT_PSEUDO_FRAME] |-> irq_o)
        else $error("enabled pseudo frame did not interrupt");

    a_setup_irq: assert property (
        s_reg.status[UIM_BIT_SETUP_DONE] && s_reg.enable[UIM_BIT_SETUP_DONE] |-> irq_o)
        else $error("enabled setup completion did not interrupt");

    a_overwrite_irq: assert property (
        s_reg.status[UIM_BIT_SETUP_OVERWRITE] && s_reg.enable[UIM_BIT_SETUP_OVERWRITE]
        |-> irq_o)
        else $error("enabled setup overwrite did not interrupt");

    a_reserved_zero: assert property (
        s_enable_wr |=> !s_reg.enable[UIM_BIT_RESERVED] && !pending_o[UIM_BIT_RESERVED])
        else $error("reserved bit took a write");

    a_enable_write: assert property (
        s_enable_wr ##1 (!wr_enable)[*2] |-> s_reg.enable == ($past(bus_i.wdata, 2) & 8'hFD))
        else $error("enable register did not hold written value");

    a_enable_read: assert property (
        s_enable_rd |=> rd_data_o == $past(s_reg.enable))
        else $error("enable register read back wrong");

    a_reset_clear: assert property (
        $fell(reset_i) |-> s_reg.enable == 8'h00 && !irq_o)
        else $error("enable bits not zero after reset");

    a_event_sticky: assert property (
        evt_i.bus_reset |=> s_reg.status[UIM_BIT_BUS_RESET]
        and (s_no_clear |=> s_reg.status[UIM_BIT_BUS_RESET]))
        else $error("bus reset status not sticky");

    a_vector_clear: assert property (
        wr_vector && (set_v == 8'h00) |=> s_reg.status == 8'h00)
        else $error("vector write did not clear status");

    a_pseudo_period: assert property (
        !frame_locked_i && s_reg.frame_cnt == FRAME_LAST
        |=> s_reg.status[UIM_BIT_PSEUDO_FRAME] && s_reg.frame_cnt == 17'h00000)
        else $error("pseudo frame did not fire at period end");

    a_pseudo_locked: assert property (
        frame_locked_i[*2] |-> s_reg.frame_cnt == 17'h00000)
        else $error("frame timer ran while locked");

    a_overwrite_flag: assert property (
        evt_i.setup_done && s_reg.status[UIM_BIT_SETUP_DONE]
        |=> s_reg.status[UIM_BIT_SETUP_OVERWRITE])
        else $error("setup overwrite not flagged");

    a_read_idle: assert property (
        !bus_i.rd |=> rd_data_o == 8'h00)
        else $error("read data stands outside read reply cycle");

    // ************************************************************
    // Register access checks
    // ************************************************************
    a_status_read: assert property (
        s_status_rd |=> rd_data_o == $past(s_reg.status))
        else $error("status register read back wrong");

    a_vector_read: assert property (
        s_vector_rd |=> rd_data_o == 8'h00)
        else $error("vector register read did not return zero");

    a_unmapped_read: assert property (
        bus_i.rd && (bus_i.addr != UIM_ADDR_ENABLE) && (bus_i.addr != UIM_ADDR_STATUS)
        |=> rd_data_o == 8'h00)
        else $error("unmapped read did not return zero");

    a_reserved_status: assert property (
        !s_reg.status[UIM_BIT_RESERVED] && !rd_data_o[UIM_BIT_RESERVED])
        else $error("reserved bit seen set");

    a_enable_clean: assert property (
        (s_reg.enable & ~UIM_IMPL_BITS) == 8'h00)
        else $error("enable register holds an unimplemented bit");

    a_enable_hold: assert property (
        !wr_enable |=> s_reg.enable == $past(s_reg.enable))
        else $error("enable register changed without a write");

    a_reset_quiet: assert property (
        $fell(reset_i) |-> s_reg.status == 8'h00 && pending_o == 8'h00 && rd_data_o == 8'h00)
        else $error("state not quiet after reset");

    // ************************************************************
    // Status and frame timer checks
    // ************************************************************
    a_status_w1c: assert property (
        wr_status && (set_v == 8'h00) |=> (s_reg.status & $past(bus_i.wdata)) == 8'h00)
        else $error("status write of one did not clear the bit");

    a_status_no_set: assert property (
        set_v == 8'h00 |=> (s_reg.status & ~$past(s_reg.status)) == 8'h00)
        else $error("status bit set without an event");

    // An event in a clearing cycle must not be lost
    a_set_wins: assert property (
        evt_i.suspend && wr_vector |=> s_reg.status[UIM_BIT_SUSPEND])
        else $error("suspend lost to a clearing write in the same cycle");

    a_suspend_set: assert property (
        evt_i.suspend |=> s_reg.status[UIM_BIT_SUSPEND])
        else $error("suspend event did not set its status bit");

    a_resume_set: assert property (
        evt_i.resume |=> s_reg.status[UIM_BIT_RESUME])
        else $error("resume event did not set its status bit");

    a_frame_set: assert property (
        evt_i.frame |=> s_reg.status[UIM_BIT_FRAME])
        else $error("frame event did not set its status bit");

    a_setup_set: assert property (
        evt_i.setup_done |=> s_reg.status[UIM_BIT_SETUP_DONE])
        else $error("setup completion did not set its status bit");

    a_overwrite_seq: assert property (
        s_setup_twice |=> s_reg.status[UIM_BIT_SETUP_OVERWRITE])
        else $error("repeated setup did not flag an overwrite");

    a_overwrite_only: assert property (
        !(evt_i.setup_done && s_reg.status[UIM_BIT_SETUP_DONE])
        && !s_reg.status[UIM_BIT_SETUP_OVERWRITE]
        |=> !s_reg.status[UIM_BIT_SETUP_OVERWRITE])
        else $error("setup overwrite flagged without a repeated setup");

    a_pseudo_only: assert property (
        (frame_locked_i || s_reg.frame_cnt != FRAME_LAST)
        && !s_reg.status[UIM_BIT_PSEUDO_FRAME]
        |=> !s_reg.status[UIM_BIT_PSEUDO_FRAME])
        else $error("pseudo frame fired outside period end");

    a_frame_count: assert property (
        !frame_locked_i && (s_reg.frame_cnt < FRAME_LAST)
        |=> s_reg.frame_cnt == $past(s_reg.frame_cnt) + UIM_FRAME_CNT_W'(1))
        else $error("frame timer did not advance while unlocked");

    // ************************************************************
    // Interrupt checks
    // ************************************************************
    a_pending_match: assert property (
        pending_o == (s_reg.status & s_reg.enable))
        else $error("pending bits do not follow status and enable");

    a_masked_silent: assert property (
        s_reg.enable == 8'h00 |-> !irq_o && pending_o == 8'h00)
        else $error("interrupt raised with every enable bit clear");

    a_irq_idle: assert property (
        s_reg.status == 8'h00 |-> !irq_o)
        else $error("interrupt raised with no status bit set");

    a_irq_rise: assert property (
        $rose(irq_o) |-> $past(set_v != 8'h00 || wr_enable))
        else $error("interrupt rose with no event and no enable write");

    // Reset may drop the line by itself, so that edge is left out
    a_irq_fall: assert property (
        $fell(irq_o) && !$past(reset_i) |-> $past(wr_vector || wr_status || wr_enable))
        else $error("interrupt fell with no clearing or enable write");

    // Each implemented bit gates alone, so a crossed bit shows here
    for (genvar b = 0; b < 8; b++) begin : g_bit_gate
        if (UIM_IMPL_BITS[b]) begin : g_impl
            a_bit_gate: assert property (
                pending_o[b] == (s_reg.status[b] && s_reg.enable[b]))
                else $error("pending bit does not follow its status and enable");
        end
    end

endmodule

// ---- test/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import uim_pkg::*;

    // ************************************************************
    // Clock, reset, stimulus signals
    // ************************************************************
    localparam int unsigned PF_CYCLES = 16;
    logic clk_i;
    logic reset_i;
    uim_bus_req_t bus;
    uim_evt_t evt;
    logic frame_locked;
    logic [7:0] rd_data;
    logic [7:0] pending;
    logic irq;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] en;
    logic [7:0] exp_st;
    int ev_bits [5] = '{7, 6, 5, 4, 2};

    uim_top #(.PSEUDO_FRAME_CYCLES(PF_CYCLES)) uim_top_inst (
        .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .evt_i(evt),
        .frame_locked_i(frame_locked), .rd_data_o(rd_data), .pending_o(pending), .irq_o(irq)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Whole run needs well under this many cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic final_report();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_pend(input logic [7:0] s, input logic [7:0] e);
        return s & e & UIM_IMPL_BITS;
    endfunction

    function automatic uim_evt_t evt_of(input int b);
        uim_evt_t v;
        v = '0;
        v.bus_reset = (b == 7);
        v.suspend = (b == 6);
        v.resume = (b == 5);
        v.frame = (b == 4);
        v.setup_done = (b == 2);
        return v;
    endfunction

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask

    task automatic pulse(input int b);
        @(posedge clk_i);
        evt <= evt_of(b);
        @(posedge clk_i);
        evt <= '0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic clear_all();
        wr(UIM_ADDR_VECTOR, 8'h00);
        exp_st = 8'h00;
        @(posedge clk_i);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        reset_i = 1'b1;
        bus = '0;
        evt = '0;
        frame_locked = 1'b1;
        exp_st = 8'h00;
        void'($urandom(4092));
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(UIM_ADDR_ENABLE, 8'h00);
        check(pending, 8'h00);
        wr(UIM_ADDR_ENABLE, 8'hFF);
        rd_chk(UIM_ADDR_ENABLE, 8'hFD);
        rd_chk(16'h1234, 8'h00);
        // Corner masks first, then random ones; reserved-only mask must stay silent
        for (int r = 0; r < 6; r++) begin
            en = (r == 0) ? 8'hFF : (r == 1) ? 8'h02 : 8'($urandom);
            wr(UIM_ADDR_ENABLE, en);
            foreach (ev_bits[k]) begin
                clear_all();
                pulse(ev_bits[k]);
                exp_st[ev_bits[k]] = 1'b1;
                check(pending, exp_pend(exp_st, en));
                check(8'(irq), 8'(|exp_pend(exp_st, en)));
                rd_chk(UIM_ADDR_STATUS, exp_st);
            end
        end
        // Two setup stages back to back flag the overwrite
        clear_all();
        wr(UIM_ADDR_ENABLE, 8'h01);
        pulse(2);
        pulse(2);
        rd_chk(UIM_ADDR_STATUS, 8'h05);
        check(pending, 8'h01);
        check(8'(irq), 8'h01);
        wr(UIM_ADDR_STATUS, 8'h01);
        rd_chk(UIM_ADDR_STATUS, 8'h04);
        check(8'(irq), 8'h00);
        // Event beside a clearing write: the event survives
        @(posedge clk_i);
        evt <= evt_of(6);
        bus <= '{addr: UIM_ADDR_VECTOR, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        evt <= '0;
        bus.wr <= 1'b0;
        rd_chk(UIM_ADDR_STATUS, 8'h40);
        rd_chk(UIM_ADDR_VECTOR, 8'h00);
        // Free-running pseudo frame while unlocked, none while locked
        clear_all();
        wr(UIM_ADDR_ENABLE, 8'h08);
        frame_locked <= 1'b0;
        repeat (PF_CYCLES + 4) @(posedge clk_i);
        frame_locked <= 1'b1;
        @(posedge clk_i);
        #1;
        check(pending, 8'h08);
        check(8'(irq), 8'h01);
        clear_all();
        repeat (PF_CYCLES + 4) @(posedge clk_i);
        #1;
        check(pending, 8'h00);
        // Second reset in mid-run
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(UIM_ADDR_ENABLE, 8'h00);
        final_report();
    end
endmodule
